// ---- io_pin_regs.svh ----
// register indices, field positions, reset values and pin numbers for the pin function block
`ifndef IO_PIN_REGS_SVH
`define IO_PIN_REGS_SVH
`define IDX_PIN_FUNCTION_CONTROL 16'hc006
`define IDX_BANK0_OUTPUT_DATA 16'hc01e
`define IDX_BANK0_INPUT_DATA 16'hc020
`define IDX_BANK0_DIRECTION 16'hc022
`define IDX_BANK1_OUTPUT_DATA 16'hc024
`define IDX_BANK1_INPUT_DATA 16'hc026
`define IDX_BANK1_DIRECTION 16'hc028
`define IDX_EVENT_STATUS 16'hc030
`define IDX_EVENT_MASK 16'hc032
`define CTRL_LOCK_BIT 15
`define CTRL_RELOC_BIT 11
`define CTRL_MODE_LSB 8
`define CTRL_HSS_BIT 7
`define CTRL_SPI_BIT 5
`define CTRL_POL_BIT 1
`define CTRL_EN_BIT 0
`define CTRL_WR_MASK 16'h8fa3
`define CTRL_RESET 16'h0000
`define BANK0_MASK 16'hffff
`define BANK1_MASK 16'he1f8
`define DATA_RESET 16'h0000
`define EVT_EDGE_BIT 0
`define EVT_LOCKED_BIT 1
`define EVT_MASK 16'h0003
`define EXT_IRQ_PIN 24
`define SS_DEFAULT_PIN 9
`define SS_RELOC_PIN 15
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- io_pin_pkg.sv ----
// types shared by the pin function block
package io_pin_pkg;
    typedef enum logic [2:0] {
        MODE_GPIO = 3'h0,
        MODE_HOST_PORT = 3'h5,
        MODE_SCAN = 3'h6
    } pin_mode_t;

    typedef struct packed {
        logic lock;
        logic [2:0] rsv_14_12;
        logic slave_select_relocation;
        logic [2:0] mode;
        logic hss_en;
        logic rsv_6;
        logic spi_en;
        logic [2:0] rsv_4_2;
        logic irq_pol;
        logic irq_en;
    } ctrl_t;

    typedef struct packed {
        logic [31:0] value;
        logic [31:0] oe;
    } pad_drive_t;

    typedef struct packed {
        logic [3:0] value;
        logic [3:0] oe;
    } quad_drive_t;

    typedef struct packed {
        logic [21:0] value;
        logic [21:0] oe;
    } port_drive_t;
endpackage

// ---- io_pin_function_control.sv ----
// pin function control: axi4-lite register file, pin mux and external interrupt line
`include "io_pin_regs.svh"

module io_pin_function_control #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pads
    input wire logic [31:0] pin_in,
    output io_pin_pkg::pad_drive_t pad_drive,
    // high-speed serial port, pins 15:12
    input wire io_pin_pkg::quad_drive_t high_speed_serial_port_drive,
    output logic [3:0] high_speed_serial_port_in,
    // spi port, pins 11:8
    input wire io_pin_pkg::quad_drive_t spi_drive,
    output logic [3:0] spi_in,
    output logic spi_slave_select_input,
    // host parallel port, pins 15:0 and 24:19
    input wire io_pin_pkg::port_drive_t host_parallel_port_drive,
    output logic [21:0] host_parallel_port_in,
    // interrupts
    input wire logic global_pin_irq_en,
    output logic external_interrupt_line_req,
    output logic irq
);
    import io_pin_pkg::*;

    logic [1:0] rst_pipe_ff;
    logic rst_sync_b;
    ctrl_t ctrl_ff;
    logic [15:0] b0_out_ff;
    logic [15:0] b0_dir_ff;
    logic [15:0] b1_out_ff;
    logic [15:0] b1_dir_ff;
    logic [15:0] evt_status_ff;
    logic [15:0] evt_mask_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [15:0] aw_idx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic rvalid_ff;
    logic [1:0] bresp_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [2:0] irq_sync_ff;
    logic req_ff;
    pad_drive_t pad_ff;
    logic wr_fire;
    logic [15:0] wr_bits;
    logic [15:0] wr_mask;
    logic [15:0] nxt_ctrl;
    logic [15:0] ar_idx;
    logic edge_seen;
    logic locked_try;
    logic [15:0] b0_in;
    logic [15:0] b1_in;
    pad_drive_t nxt_pad;
    pin_mode_t mode;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe_ff[1];

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_idx_ff <= 16'h0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_idx_ff <= s_axi_awaddr[17:2];
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // byte lanes 0 and 1 carry the 16-bit registers
    assign wr_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_bits = wdata_ff[15:0];

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            unique case (aw_idx_ff)
                `IDX_PIN_FUNCTION_CONTROL,
                `IDX_BANK0_OUTPUT_DATA,
                `IDX_BANK0_INPUT_DATA,
                `IDX_BANK0_DIRECTION,
                `IDX_BANK1_OUTPUT_DATA,
                `IDX_BANK1_INPUT_DATA,
                `IDX_BANK1_DIRECTION,
                `IDX_EVENT_STATUS,
                `IDX_EVENT_MASK: begin
                    bresp_ff <= `RESP_OKAY;
                end
                default: begin
                    bresp_ff <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // control register; the lock holds the upper byte until chip reset
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_fire && aw_idx_ff == `IDX_PIN_FUNCTION_CONTROL) begin
            nxt_ctrl[7:0] = (ctrl_ff[7:0] & ~wr_mask[7:0])
                | (wr_bits[7:0] & wr_mask[7:0]);
            if (!ctrl_ff.lock) begin
                nxt_ctrl[15:8] = (ctrl_ff[15:8] & ~wr_mask[15:8])
                    | (wr_bits[15:8] & wr_mask[15:8]);
            end
            // reserved positions never store, so they read as zero
            nxt_ctrl = nxt_ctrl & `CTRL_WR_MASK;
        end
    end
    assign locked_try = wr_fire && aw_idx_ff == `IDX_PIN_FUNCTION_CONTROL
        && ctrl_ff.lock && wr_mask[8];

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl_ff <= ctrl_t'(`CTRL_RESET);
        end else begin
            ctrl_ff <= ctrl_t'(nxt_ctrl);
        end
    end

    // output and direction registers read back what was written in the populated positions
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            b0_out_ff <= `DATA_RESET;
            b0_dir_ff <= `DATA_RESET;
            b1_out_ff <= `DATA_RESET;
            b1_dir_ff <= `DATA_RESET;
        end else if (wr_fire) begin
            unique case (aw_idx_ff)
                `IDX_BANK0_OUTPUT_DATA: begin
                    b0_out_ff <= ((b0_out_ff & ~wr_mask) | (wr_bits & wr_mask)) & `BANK0_MASK;
                end
                `IDX_BANK0_DIRECTION: begin
                    b0_dir_ff <= ((b0_dir_ff & ~wr_mask) | (wr_bits & wr_mask)) & `BANK0_MASK;
                end
                `IDX_BANK1_OUTPUT_DATA: begin
                    b1_out_ff <= ((b1_out_ff & ~wr_mask) | (wr_bits & wr_mask)) & `BANK1_MASK;
                end
                `IDX_BANK1_DIRECTION: begin
                    b1_dir_ff <= ((b1_dir_ff & ~wr_mask) | (wr_bits & wr_mask)) & `BANK1_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // pin 24 synchroniser; only the second and third stages feed the edge test
    // resets low, so a pin idling high may look like an edge; irq_en resets clear
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_sync_ff <= 3'h0;
        end else begin
            irq_sync_ff <= {irq_sync_ff[1:0], pin_in[`EXT_IRQ_PIN]};
        end
    end
    assign edge_seen = ctrl_ff.irq_pol ? (irq_sync_ff[1] && !irq_sync_ff[2])
        : (!irq_sync_ff[1] && irq_sync_ff[2]);

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= edge_seen && ctrl_ff.irq_en && global_pin_irq_en;
        end
    end
    assign external_interrupt_line_req = req_ff;

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            evt_status_ff <= 16'h0000;
            evt_mask_ff <= 16'h0000;
        end else begin
            if (wr_fire && aw_idx_ff == `IDX_EVENT_STATUS) begin
                evt_status_ff <= evt_status_ff & ~(wr_bits & wr_mask)
                    | {14'h0000, locked_try, req_ff};
            end else begin
                evt_status_ff <= evt_status_ff | {14'h0000, locked_try, req_ff};
            end
            if (wr_fire && aw_idx_ff == `IDX_EVENT_MASK) begin
                evt_mask_ff <= ((evt_mask_ff & ~wr_mask) | (wr_bits & wr_mask)) & `EVT_MASK;
            end
        end
    end
    assign irq = |(evt_status_ff & evt_mask_ff);

    // input registers show pin levels in the populated positions
    // raw pins, no synchroniser: software sees the level at the address edge
    assign b0_in = pin_in[15:0] & `BANK0_MASK;
    assign b1_in = {pin_in[31:29], 4'h0, pin_in[24:19], 3'h0} & `BANK1_MASK;

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_ff;
    assign ar_idx = s_axi_araddr[17:2];

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `RESP_OKAY;
            unique case (ar_idx)
                `IDX_PIN_FUNCTION_CONTROL: rdata_ff <= {16'h0000, ctrl_ff};
                `IDX_BANK0_OUTPUT_DATA: rdata_ff <= {16'h0000, b0_out_ff};
                `IDX_BANK0_INPUT_DATA: rdata_ff <= {16'h0000, b0_in};
                `IDX_BANK0_DIRECTION: rdata_ff <= {16'h0000, b0_dir_ff};
                `IDX_BANK1_OUTPUT_DATA: rdata_ff <= {16'h0000, b1_out_ff};
                `IDX_BANK1_INPUT_DATA: rdata_ff <= {16'h0000, b1_in};
                `IDX_BANK1_DIRECTION: rdata_ff <= {16'h0000, b1_dir_ff};
                `IDX_EVENT_STATUS: rdata_ff <= {16'h0000, evt_status_ff};
                `IDX_EVENT_MASK: rdata_ff <= {16'h0000, evt_mask_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // pin mux; reserved and scan codes act as the gpio code
    assign mode = pin_mode_t'(ctrl_ff.mode);

    always_comb begin
        nxt_pad.value = {b1_out_ff[15:13], 4'h0, b1_out_ff[8:3], 3'h0, b0_out_ff};
        nxt_pad.oe = {b1_dir_ff[15:13], 4'h0, b1_dir_ff[8:3], 3'h0, b0_dir_ff};
        if (mode == MODE_HOST_PORT) begin
            nxt_pad.value[15:0] = host_parallel_port_drive.value[15:0];
            nxt_pad.oe[15:0] = host_parallel_port_drive.oe[15:0];
            nxt_pad.value[24:19] = host_parallel_port_drive.value[21:16];
            nxt_pad.oe[24:19] = host_parallel_port_drive.oe[21:16];
        end else begin
            if (ctrl_ff.hss_en) begin
                nxt_pad.value[15:12] = high_speed_serial_port_drive.value;
                nxt_pad.oe[15:12] = high_speed_serial_port_drive.oe;
            end
            if (ctrl_ff.spi_en) begin
                nxt_pad.value[11:8] = spi_drive.value;
                nxt_pad.oe[11:8] = spi_drive.oe;
                if (ctrl_ff.slave_select_relocation) begin
                    // pin 15 turns into the slave-select input, over the serial port
                    nxt_pad.oe[`SS_RELOC_PIN] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pad_ff <= '0;
        end else begin
            pad_ff <= nxt_pad;
        end
    end
    // one cycle of latency bought to keep the enables free of mux glitches
    assign pad_drive = pad_ff;

    assign high_speed_serial_port_in = pin_in[15:12];
    assign spi_in = pin_in[11:8];
    assign spi_slave_select_input = (ctrl_ff.spi_en && ctrl_ff.slave_select_relocation)
        ? pin_in[`SS_RELOC_PIN] : pin_in[`SS_DEFAULT_PIN];
    assign host_parallel_port_in = {pin_in[24:19], pin_in[15:0]};

endmodule // io_pin_function_control

// ---- io_pin_function_control_sva.sv ----
// port-level assertions for the pin function block
module io_pin_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and ports
    input wire logic [31:0] pin_in,
    input wire logic [3:0] high_speed_serial_port_in,
    input wire logic [3:0] spi_in,
    input wire logic spi_slave_select_input,
    input wire logic [21:0] host_parallel_port_in,
    input wire logic global_pin_irq_en,
    input wire logic external_interrupt_line_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // wide window: the pulse lands a few edges after the pin moves
    sequence s_pin_moved;
        $past(pin_in[24], 2) != $past(pin_in[24], 6);
    endsequence
    a_hss_in_route: assert property (high_speed_serial_port_in == pin_in[15:12])
        else $error("serial port input not taken from pins 15:12");
    a_spi_in_route: assert property (spi_in == pin_in[11:8])
        else $error("spi input not taken from pins 11:8");
    a_host_in_route: assert property (
        host_parallel_port_in == {pin_in[24:19], pin_in[15:0]})
        else $error("host port input not taken from its pins");
    a_ss_pin_src: assert property (
        spi_slave_select_input == pin_in[9] || spi_slave_select_input == pin_in[15])
        else $error("slave select from an unexpected pin");
    a_req_one_pulse: assert property (
        external_interrupt_line_req |=> !external_interrupt_line_req)
        else $error("interrupt request wider than one cycle");
    a_req_needs_gate: assert property (
        external_interrupt_line_req |-> $past(global_pin_irq_en))
        else $error("interrupt request with global enable low");
    a_req_from_edge: assert property (
        external_interrupt_line_req |-> s_pin_moved)
        else $error("interrupt request without a pin 24 edge");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before ready");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    a_aw_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");
endmodule // io_pin_checker

bind io_pin_function_control io_pin_checker chk (.clk(clk), .rst_b(rst_b),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_in(pin_in), .high_speed_serial_port_in(high_speed_serial_port_in), .spi_in(spi_in),
    .spi_slave_select_input(spi_slave_select_input),
    .host_parallel_port_in(host_parallel_port_in),
    .global_pin_irq_en(global_pin_irq_en),
    .external_interrupt_line_req(external_interrupt_line_req));

// ---- io_pin_function_control_tb_top.sv ----
// self-checking bench for the pin function block
`include "io_pin_regs.svh"
module io_pin_function_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import io_pin_pkg::*;
    logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic gen = 0, awready, wready, bvalid, arready, rvalid, ss, req, irq;
    logic [17:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, pins = 0, rdata, seed = 32'h627c;
    logic [3:0] wstrb = 0, hin, sin;
    logic [1:0] bresp, rresp;
    logic [21:0] pin_host;
    quad_drive_t hsd = '0, spd = '0;
    port_drive_t hpd = '0;
    pad_drive_t pad;
    logic [15:0] mdl [logic [15:0]];
    logic [15:0] stat = 0;
    logic [15:0] regs [10] = '{`IDX_PIN_FUNCTION_CONTROL, `IDX_BANK0_OUTPUT_DATA,
        `IDX_BANK0_INPUT_DATA, `IDX_BANK0_DIRECTION, `IDX_BANK1_OUTPUT_DATA,
        `IDX_BANK1_INPUT_DATA, `IDX_BANK1_DIRECTION, `IDX_EVENT_STATUS, `IDX_EVENT_MASK, 16'hc008};
    logic [4:0] tbl [8] = '{5'b11111, 5'b00111, 5'b01101, 5'b10101, 5'b01110, 5'b00110,
        5'b01011, 5'b10101};
    int err_count = 0, checked = 0, cyc = 0;

    io_pin_function_control uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pins), .pad_drive(pad), .high_speed_serial_port_drive(hsd),
        .high_speed_serial_port_in(hin), .spi_drive(spd), .spi_in(sin),
        .spi_slave_select_input(ss), .host_parallel_port_drive(hpd),
        .host_parallel_port_in(pin_host), .global_pin_irq_en(gen),
        .external_interrupt_line_req(req), .irq(irq));

    initial forever #50 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // locked control keeps only the low byte writable
    function automatic logic [15:0] wmask(logic [15:0] idx);
        case (idx)
            `IDX_PIN_FUNCTION_CONTROL: return mdl[idx][15] ? 16'h00a3 : `CTRL_WR_MASK;
            `IDX_BANK0_OUTPUT_DATA, `IDX_BANK0_DIRECTION: return `BANK0_MASK;
            `IDX_BANK1_OUTPUT_DATA, `IDX_BANK1_DIRECTION: return `BANK1_MASK;
            `IDX_EVENT_MASK: return `EVT_MASK;
            default: return 16'h0;
        endcase
    endfunction

    function automatic logic [15:0] mrd(logic [15:0] idx);
        case (idx)
            `IDX_BANK0_INPUT_DATA: return pins[15:0];
            `IDX_BANK1_INPUT_DATA: return pins[31:16] & `BANK1_MASK;
            `IDX_EVENT_STATUS: return stat;
            default: return mdl[idx];
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_b <= 0;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        stat = 0;
        foreach (regs[i]) mdl[regs[i]] = 0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] st);
        logic aw_t, w_t, b_t;
        logic [15:0] m;
        @(posedge clk);
        aw_t = 0;
        w_t = 0;
        b_t = 0;
        m = wmask(idx) & {{8{st[1]}}, {8{st[0]}}};
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0, d};
        wstrb <= st;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b_t) begin
            @(negedge clk);
            aw_t = aw_t | (awvalid & awready);
            w_t = w_t | (wvalid & wready);
            b_t = bvalid;
            if (b_t) chk(bresp, idx == 16'hc008 ? `RESP_SLVERR : `RESP_OKAY);
            @(posedge clk);
            if (aw_t) awvalid <= 0;
            if (w_t) wvalid <= 0;
        end
        bready <= 0;
        if (idx == `IDX_EVENT_STATUS) stat = stat & ~(d & `EVT_MASK & {8'h0, {8{st[0]}}});
        if (idx == `IDX_PIN_FUNCTION_CONTROL && mdl[idx][15] && st[1]) stat[1] = 1;
        mdl[idx] = (mdl[idx] & ~m) | (d & m);
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] idx);
        logic a_t, r_t;
        @(posedge clk);
        a_t = 0;
        r_t = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        while (!r_t) begin
            @(negedge clk);
            a_t = a_t | (arvalid & arready);
            r_t = rvalid;
            if (r_t) chk(rdata, {16'h0, mrd(idx)});
            if (r_t) chk(rresp, idx == 16'hc008 ? `RESP_SLVERR : `RESP_OKAY);
            @(posedge clk);
            if (a_t) arvalid <= 0;
        end
        rready <= 0;
        @(posedge clk);
    endtask

    task automatic irq_try(input logic [4:0] e);
        int seen;
        seen = 0;
        wr(`IDX_EVENT_STATUS, 16'h3, 4'h1);
        chk(irq, 0);
        wr(`IDX_PIN_FUNCTION_CONTROL, {14'h0, e[1:0]}, 4'h3);
        gen <= e[2];
        @(posedge clk);
        pins[24] <= e[3];
        repeat (12) begin
            @(negedge clk);
            seen += (req === 1'b1);
            @(posedge clk);
        end
        chk(seen, e[4]);
        stat[0] = stat[0] | e[4];
        chk(irq, |(stat & mdl[`IDX_EVENT_MASK]));
        rd(`IDX_EVENT_STATUS);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] idx, d;
        do_reset();
        foreach (regs[i]) rd(regs[i]);
        repeat (40) begin
            r = rnd();
            idx = regs[r[31:16] % 10];
            d = 16'(rnd());
            // software keeps reserved bits, the lock and the scan code out of play
            if (idx == `IDX_PIN_FUNCTION_CONTROL) d = d & 16'h0fa3;
            else if (wmask(idx) != 0) d = d & wmask(idx);
            else if (idx == `IDX_BANK1_INPUT_DATA) d = d & `BANK1_MASK;
            else if (idx == `IDX_EVENT_STATUS) d = d & `EVT_MASK;
            if (idx == `IDX_PIN_FUNCTION_CONTROL && d[10:8] == 3'h6) d[10:8] = 3'h0;
            pins <= (rnd() & 32'hfeffffff) | (pins & 32'h01000000);
            hsd <= r[7:0];
            spd <= r[15:8];
            hpd <= {r[11:0], r};
            wr(idx, d, r[3:0]);
            rd(idx);
        end
        wr(`IDX_BANK0_DIRECTION, 16'hffff, 4'h3);
        wr(`IDX_BANK0_OUTPUT_DATA, 16'ha5c3, 4'h3);
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h0000, 4'h3);
        @(negedge clk);
        chk({pad.oe[15:0], pad.value[15:0]}, 32'hffffa5c3);
        wr(`IDX_BANK1_DIRECTION, 16'hffff, 4'h3);
        wr(`IDX_BANK1_OUTPUT_DATA, 16'h5a5a, 4'h3);
        @(negedge clk);
        chk({pad.oe[31:16], pad.value[31:16]}, {`BANK1_MASK, 16'h5a5a & `BANK1_MASK});
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h00a0, 4'h3);
        @(negedge clk);
        chk(pad.value[15:8], {hsd.value, spd.value});
        chk(pad.oe[15:8], {hsd.oe, spd.oe});
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h0500, 4'h3);
        @(negedge clk);
        chk({pad.value[24:19], pad.value[15:0]}, hpd.value);
        chk({pad.oe[24:19], pad.oe[15:0]}, hpd.oe);
        @(posedge clk);
        pins[9] <= 1;
        pins[15] <= 0;
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h0020, 4'h3);
        chk(ss, 1);
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h08a0, 4'h3);
        chk(ss, 0);
        @(negedge clk);
        chk(pad.oe[15:8], {1'b0, hsd.oe[2:0], spd.oe});
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h0800, 4'h3);
        chk(ss, 1);
        pins[24] <= 0;
        wr(`IDX_EVENT_MASK, 16'h3, 4'h1);
        foreach (tbl[i]) begin
            if (i == 7) wr(`IDX_EVENT_MASK, 16'h0, 4'h1);
            irq_try(tbl[i]);
        end
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h8020, 4'h3);
        wr(`IDX_PIN_FUNCTION_CONTROL, 16'h0701, 4'h3);
        rd(`IDX_PIN_FUNCTION_CONTROL);
        rd(`IDX_EVENT_STATUS);
        wr(`IDX_EVENT_MASK, 16'h2, 4'h1);
        chk(irq, 1);
        do_reset();
        rd(`IDX_PIN_FUNCTION_CONTROL);
        stop_test();
    end
endmodule // io_pin_function_control_tb_top
